// file: logic/spn_pkg.sv
// shared constants and types for the serial ports and indicator block
package spn_pkg;
  // core clock
  localparam int unsigned CLK_HZ = 125_000_000;
  // line rates in bits per second
  localparam int unsigned BAUD_CMD = 9600;
  localparam int unsigned BAUD_FW = 115200;
  localparam int unsigned BAUD_LOG = 921600;
  // bit periods in core cycles, rounded to nearest
  localparam int unsigned DIV_CMD = (CLK_HZ + BAUD_CMD / 2) / BAUD_CMD;
  localparam int unsigned DIV_FW = (CLK_HZ + BAUD_FW / 2) / BAUD_FW;
  localparam int unsigned DIV_LOG = (CLK_HZ + BAUD_LOG / 2) / BAUD_LOG;
  // call alert low time
  localparam int unsigned ALERT_MS = 120;
  localparam int unsigned ALERT_CYC = CLK_HZ / 1000 * ALERT_MS;
  // real-time clock tick, 32.768 kHz
  localparam int unsigned RTC_HZ = 32768;
  localparam int unsigned RTC_DIV = CLK_HZ / RTC_HZ;
  // widths and sizes
  localparam int unsigned CNT_W = 24;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADC_W = 10;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [1:0] {
    SPN_IDLE = 2'b00,
    SPN_START = 2'b01,
    SPN_DATA = 2'b10,
    SPN_STOP = 2'b11
  } spn_phase_type;

  // one serial engine, transmit or receive
  typedef struct packed {
    spn_phase_type phase;
    logic [CNT_W-1:0] cnt;
    logic [2:0] idx;
    logic [DATA_W-1:0] shreg;
    logic line;
  } spn_ser_type;

  typedef struct packed {
    spn_ser_type mtx;
    spn_ser_type ltx;
    spn_ser_type mrx;
    logic rx_valid;
    logic [DATA_W-1:0] rx_data;
    logic rx_err;
    logic [CNT_W-1:0] alert_cnt;
    logic alert;
    logic lamp;
    logic [ADC_W-1:0] adc;
    logic radio_en;
    logic wake;
    logic [11:0] rtc_div;
    logic [31:0] rtc_count;
  } spn_state_type;

  localparam spn_ser_type SPN_SER_RST = '{
    phase: SPN_IDLE, cnt: '0, idx: '0, shreg: '0, line: LINE_IDLE};
  localparam spn_state_type SPN_STATE_RST = '{
    mtx: SPN_SER_RST, ltx: SPN_SER_RST, mrx: SPN_SER_RST,
    rx_valid: 1'b0, rx_data: '0, rx_err: 1'b0, alert_cnt: '0, alert: 1'b1,
    lamp: 1'b0, adc: '0, radio_en: 1'b0, wake: 1'b0, rtc_div: '0, rtc_count: '0};
endpackage

// file: logic/spn_fifo.sv
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ns
module spn_fifo
  import spn_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } spn_fifo_type;

  spn_fifo_type state_reg;
  spn_fifo_type state_next;
  logic push;
  logic pop;

  // handshakes
  assign in_ready = (state_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (state_reg.count != '0);
  assign out_data = state_reg.mem[state_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and storage update
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.wr] = in_data;
      state_next.wr = (state_reg.wr == AW'(DEPTH - 1)) ? '0 : state_reg.wr + 1'b1;
    end
    if (pop)
    begin
      state_next.rd = (state_reg.rd == AW'(DEPTH - 1)) ? '0 : state_reg.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: state_next.count = state_reg.count + 1'b1;
      2'b01: state_next.count = state_reg.count - 1'b1;
      default: state_next.count = state_reg.count;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  a_fifo_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_reg.count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule

// file: logic/spn_top.sv
// main and log serial ports, call alert, network lamp and power-state glue
`timescale 1ns/1ns
module spn_top
  import spn_pkg::*;
#(
  parameter int unsigned DIV_CMD_P = DIV_CMD,
  parameter int unsigned DIV_FW_P = DIV_FW,
  parameter int unsigned DIV_LOG_P = DIV_LOG,
  parameter int unsigned ALERT_CYC_P = ALERT_CYC,
  parameter int unsigned RTC_DIV_P = RTC_DIV
)(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic main_serial_in,
  output logic main_serial_out,
  input wire logic log_serial_in,
  output logic log_serial_out,
  input wire logic upgrade_mode,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_frame_error,
  input wire logic log_valid,
  output logic log_ready,
  input wire logic [DATA_W-1:0] log_data,
  input wire logic sms_event,
  input wire logic report_event,
  output logic call_alert_out,
  input wire logic device_working,
  input wire logic net_attached,
  output logic network_lamp,
  input wire logic deep_sleep_state,
  input wire logic tau_expired,
  output logic wake_request,
  output logic radio_enable,
  input wire logic adc_strobe,
  input wire logic [ADC_W-1:0] adc_sample,
  output logic [ADC_W-1:0] adc_value,
  output logic [31:0] rtc_count
);
  localparam logic [CNT_W-1:0] DCMD = CNT_W'(DIV_CMD_P);
  localparam logic [CNT_W-1:0] DFW = CNT_W'(DIV_FW_P);
  localparam logic [CNT_W-1:0] DLOG = CNT_W'(DIV_LOG_P);
  localparam logic [CNT_W-1:0] DALERT = CNT_W'(ALERT_CYC_P);
  localparam logic [11:0] DRTC = 12'(RTC_DIV_P);

  spn_state_type state_reg;
  spn_state_type state_next;
  logic [CNT_W-1:0] main_div;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic main_go;

  // one transmit engine step; line is registered with the state
  function automatic spn_ser_type tx_step(spn_ser_type t, logic go,
                                          logic [DATA_W-1:0] d, logic [CNT_W-1:0] div);
    spn_ser_type n;
    n = t;
    case (t.phase)
      SPN_IDLE:
      begin
        n.line = LINE_IDLE;
        if (go)
        begin
          n.phase = SPN_START;
          n.shreg = d;
          n.cnt = div - 1'b1;
          n.line = 1'b0;
        end
      end
      SPN_START:
      begin
        n.cnt = t.cnt - 1'b1;
        if (t.cnt == '0)
        begin
          n.phase = SPN_DATA;
          n.idx = '0;
          n.cnt = div - 1'b1;
          n.line = t.shreg[0];
        end
      end
      SPN_DATA:
      begin
        n.cnt = t.cnt - 1'b1;
        if (t.cnt == '0)
        begin
          n.cnt = div - 1'b1;
          if (t.idx == 3'h7)
          begin
            n.phase = SPN_STOP;
            n.line = LINE_IDLE;
          end
          else
          begin
            n.idx = t.idx + 1'b1;
            n.shreg = {1'b0, t.shreg[DATA_W-1:1]};
            n.line = t.shreg[1];
          end
        end
      end
      SPN_STOP:
      begin
        n.cnt = t.cnt - 1'b1;
        if (t.cnt == '0)
        begin
          // park the counter at zero so an idle transmit engine never shows a wrapped count
          n.phase = SPN_IDLE;
          n.cnt = '0;
        end
      end
      default: n = SPN_SER_RST;
    endcase
    return n;
  endfunction

  // rate choice for the main port
  assign main_div = upgrade_mode ? DFW : DCMD;

  // outgoing main data waits in the fifo
  assign main_go = fifo_valid && (state_reg.mtx.phase == SPN_IDLE);
  spn_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(state_reg.mtx.phase == SPN_IDLE),
    .out_data(fifo_data)
  );

  assign log_ready = (state_reg.ltx.phase == SPN_IDLE);

  // all next-state logic
  always_comb
  begin
    state_next = state_reg;
    state_next.rx_valid = 1'b0;
    state_next.rx_err = 1'b0;
    // main port is never gated by power state
    state_next.mtx = tx_step(state_reg.mtx, main_go, fifo_data, main_div);
    state_next.ltx = tx_step(state_reg.ltx, log_valid, log_data, DLOG);
    // main receive, sampled at mid-bit
    case (state_reg.mrx.phase)
      SPN_IDLE:
      begin
        if (!main_serial_in)
        begin
          state_next.mrx.phase = SPN_START;
          state_next.mrx.cnt = main_div >> 1;
        end
      end
      SPN_START:
      begin
        state_next.mrx.cnt = state_reg.mrx.cnt - 1'b1;
        if (state_reg.mrx.cnt == '0)
        begin
          state_next.mrx.phase = main_serial_in ? SPN_IDLE : SPN_DATA;
          state_next.mrx.cnt = main_div - 1'b1;
          state_next.mrx.idx = '0;
        end
      end
      SPN_DATA:
      begin
        state_next.mrx.cnt = state_reg.mrx.cnt - 1'b1;
        if (state_reg.mrx.cnt == '0)
        begin
          state_next.mrx.shreg = {main_serial_in, state_reg.mrx.shreg[DATA_W-1:1]};
          state_next.mrx.cnt = main_div - 1'b1;
          state_next.mrx.idx = state_reg.mrx.idx + 1'b1;
          if (state_reg.mrx.idx == 3'h7)
            state_next.mrx.phase = SPN_STOP;
        end
      end
      SPN_STOP:
      begin
        state_next.mrx.cnt = state_reg.mrx.cnt - 1'b1;
        if (state_reg.mrx.cnt == '0)
        begin
          state_next.mrx.phase = SPN_IDLE;
          state_next.rx_valid = main_serial_in;
          state_next.rx_err = !main_serial_in;
          if (main_serial_in)
            state_next.rx_data = state_reg.mrx.shreg;
        end
      end
      default: state_next.mrx = SPN_SER_RST;
    endcase
    // call alert: low for a fixed time, a new event restarts it
    if (sms_event || report_event)
    begin
      state_next.alert = 1'b0;
      state_next.alert_cnt = DALERT - 1'b1;
    end
    else if (state_reg.alert_cnt != '0)
      state_next.alert_cnt = state_reg.alert_cnt - 1'b1;
    else
      state_next.alert = 1'b1;
    // network lamp
    state_next.lamp = device_working && net_attached;
    // sample capture outside deep sleep only
    if (adc_strobe && !deep_sleep_state)
      state_next.adc = adc_sample;
    // radio off in deep sleep, slow clock always runs
    state_next.radio_en = !deep_sleep_state;
    if (state_reg.rtc_div == DRTC - 1'b1)
    begin
      state_next.rtc_div = '0;
      state_next.rtc_count = state_reg.rtc_count + 1'b1;
    end
    else
      state_next.rtc_div = state_reg.rtc_div + 1'b1;
    // wake on outgoing data or update timer
    state_next.wake = deep_sleep_state && (fifo_valid || log_valid || tau_expired);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= SPN_STATE_RST;
    else
      state_reg <= state_next;
  end

  // outputs from flip-flops
  assign main_serial_out = state_reg.mtx.line;
  assign log_serial_out = state_reg.ltx.line;
  assign rx_valid = state_reg.rx_valid;
  assign rx_data = state_reg.rx_data;
  assign rx_frame_error = state_reg.rx_err;
  assign call_alert_out = state_reg.alert;
  assign network_lamp = state_reg.lamp;
  assign adc_value = state_reg.adc;
  assign radio_enable = state_reg.radio_en;
  assign wake_request = state_reg.wake;
  assign rtc_count = state_reg.rtc_count;

  a_main_start_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
    main_go |=> !main_serial_out ##0 state_reg.mtx.shreg == $past(fifo_data))
    else $error("main start bit or byte not taken");
  a_main_rate_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_reg.mtx.cnt < (upgrade_mode ? DFW : DCMD) || $changed(upgrade_mode))
    else $error("main bit counter exceeds selected period");
  a_fw_rate_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    main_go && upgrade_mode |=> state_reg.mtx.cnt == DFW - 1'b1)
    else $error("upgrade rate not loaded");
  a_sleep_port_runs: assert property (@(posedge core_clk) disable iff (!rst_b)
    deep_sleep_state && state_reg.mtx.phase == SPN_DATA && state_reg.mtx.cnt != '0
    |=> state_reg.mtx.cnt == $past(state_reg.mtx.cnt) - 1'b1)
    else $error("main port stalled in deep sleep");
  a_log_rate_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    log_valid && log_ready |=> state_reg.ltx.cnt == DLOG - 1'b1 ##0 !log_serial_out)
    else $error("log rate not loaded");
  a_alert_fall: assert property (@(posedge core_clk) disable iff (!rst_b)
    sms_event |=> !call_alert_out ##1 !call_alert_out)
    else $error("alert did not go low on message");
  a_alert_length: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(call_alert_out) |-> $past(state_reg.alert_cnt) == '0 && !$past(report_event))
    else $error("alert released early");
  a_lamp_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    !device_working || !net_attached |=> !network_lamp)
    else $error("lamp lit while detached");
  a_lamp_on: assert property (@(posedge core_clk) disable iff (!rst_b)
    device_working && net_attached |=> network_lamp)
    else $error("lamp dark while attached");
  a_adc_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    deep_sleep_state |=> $stable(adc_value))
    else $error("sample taken in deep sleep");
  a_radio_sleep: assert property (@(posedge core_clk) disable iff (!rst_b)
    deep_sleep_state [*2] |-> !radio_enable)
    else $error("radio on in deep sleep");
  a_wake_tau: assert property (@(posedge core_clk) disable iff (!rst_b)
    deep_sleep_state && tau_expired |=> wake_request)
    else $error("no wake on timer expiry");
  a_rx_stop_bit: assert property (@(posedge core_clk) disable iff (!rst_b)
    rx_valid |-> $past(main_serial_in) && $past(state_reg.mrx.phase) == SPN_STOP)
    else $error("byte delivered without stop bit");
endmodule

// file: dv/spn_host.sv
// host terminal model: sends on the main line, decodes the main and log lines
`timescale 1ns/1ns
module spn_host
  import spn_pkg::*;
#(
  parameter int unsigned DIV_CMD_P = 16,
  parameter int unsigned DIV_FW_P = 8,
  parameter int unsigned DIV_LOG_P = 4
)(
  input wire logic core_clk,
  input wire logic upgrade_mode,
  input wire logic main_serial_out,
  input wire logic log_serial_out,
  output logic main_serial_in
);
  logic [DATA_W:0] main_q[$];
  logic [DATA_W:0] log_q[$];
  logic [DATA_W:0] mb;
  logic [DATA_W:0] lb;
  int unsigned main_div;
  // main line rate follows the mode pin
  assign main_div = upgrade_mode ? DIV_FW_P : DIV_CMD_P;
  initial main_serial_in = LINE_IDLE;
  // one frame toward the block, called at a rising edge
  task automatic send(input logic [DATA_W-1:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      main_serial_in <= f[i];
      repeat (main_div) @(posedge core_clk);
    end
    main_serial_in <= LINE_IDLE;
    @(posedge core_clk);
  endtask
  // mid-bit sampling, eight bits lsb first then stop as top bit
  task automatic grab(input bit lg, output logic [DATA_W:0] b);
    int unsigned d;
    d = lg ? DIV_LOG_P : main_div;
    repeat (d / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (d) @(posedge core_clk);
      b[i] = lg ? log_serial_out : main_serial_out;
    end
  endtask
  // main line decoder
  always
  begin
    @(negedge main_serial_out);
    grab(1'b0, mb);
    main_q.push_back(mb);
  end
  // log line decoder
  always
  begin
    @(negedge log_serial_out);
    grab(1'b1, lb);
    log_q.push_back(lb);
  end
endmodule

// file: dv/tb_top.sv
// top testbench for the serial ports and indicator block
`timescale 1ns/1ns
module tb_top
  import spn_pkg::*;
();
  logic core_clk, rst_b, main_serial_in, main_serial_out, log_serial_out, upgrade_mode;
  logic log_serial_in;
  logic tx_valid, tx_ready, rx_valid, rx_frame_error, log_valid, log_ready, sms_event;
  logic report_event, call_alert_out, device_working, net_attached, network_lamp;
  logic deep_sleep_state, tau_expired, wake_request, radio_enable, adc_strobe;
  logic [DATA_W-1:0] tx_data, rx_data, log_data;
  logic [ADC_W-1:0] adc_sample, adc_value;
  logic [31:0] rtc_count, seed, t0;
  logic [DATA_W:0] rx_q[$], exp_q[$], got;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int n;

  spn_top #(.DIV_CMD_P(16), .DIV_FW_P(8), .DIV_LOG_P(4), .ALERT_CYC_P(20),
    .RTC_DIV_P(4)) u_spn_top (.core_clk(core_clk), .rst_b(rst_b),
    .main_serial_in(main_serial_in), .main_serial_out(main_serial_out),
    .log_serial_in(log_serial_in), .log_serial_out(log_serial_out),
    .upgrade_mode(upgrade_mode),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_frame_error(rx_frame_error), .log_valid(log_valid),
    .log_ready(log_ready), .log_data(log_data), .sms_event(sms_event),
    .report_event(report_event), .call_alert_out(call_alert_out),
    .device_working(device_working), .net_attached(net_attached),
    .network_lamp(network_lamp), .deep_sleep_state(deep_sleep_state),
    .tau_expired(tau_expired), .wake_request(wake_request), .radio_enable(radio_enable),
    .adc_strobe(adc_strobe), .adc_sample(adc_sample), .adc_value(adc_value),
    .rtc_count(rtc_count));

  spn_host u_spn_host (
    .core_clk(core_clk), .upgrade_mode(upgrade_mode), .main_serial_out(main_serial_out),
    .log_serial_out(log_serial_out), .main_serial_in(main_serial_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // settle after n edges, sample at the falling edge
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // random byte to the main fifo or the log port, held until accepted
  task automatic push(input bit lg);
    seed = lfsr(seed);
    exp_q.push_back({1'b1, seed[7:0]});
    if (lg)
      log_data <= seed[7:0];
    else
      tx_data <= seed[7:0];
    log_valid <= lg;
    tx_valid <= !lg;
    do @(posedge core_clk); while ((lg ? log_ready : tx_ready) !== 1'b1);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // received bytes, frame errors as zero, and the hang limit
  always @(posedge core_clk)
  begin
    // unused log receive line still sees random traffic
    log_serial_in <= seed[0];
    if (rx_valid === 1'b1)
      rx_q.push_back({1'b1, rx_data});
    if (rx_frame_error === 1'b1)
      rx_q.push_back(9'h000);
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  initial
  begin
    {rst_b, upgrade_mode, tx_valid, log_valid, sms_event, report_event} = '0;
    {device_working, net_attached, deep_sleep_state, tau_expired, adc_strobe} = '0;
    {tx_data, log_data, adc_sample} = '0;
    seed = 32'hca7a75ab;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(2);
    chk(call_alert_out, 1);
    chk(main_serial_out, LINE_IDLE);
    chk(radio_enable, 1);
    chk(log_ready, 1);
    // every lamp input combination
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      {device_working, net_attached} <= i[1:0];
      tick(2);
      chk(network_lamp, i == 3);
    end
    // message then report event, count low cycles
    for (int e = 0; e < 2; e++)
    begin
      @(posedge core_clk);
      {sms_event, report_event} <= e ? 2'b01 : 2'b10;
      @(posedge core_clk);
      {sms_event, report_event} <= 2'b00;
      n = 0;
      repeat (60)
      begin
        @(negedge core_clk);
        n += (call_alert_out === 1'b0);
      end
      chk(n, 20);
    end
    // command rate, firmware rate with fifo filled to refusal, log port
    for (int m = 0; m < 3; m++)
    begin
      @(posedge core_clk);
      upgrade_mode <= m[0];
      exp_q = {};
      n = (m == 1) ? 17 : 3 + m;
      for (int k = 0; k < n; k++)
        push(m == 2);
      tx_valid <= 1'b0;
      log_valid <= 1'b0;
      tick(0);
      if (m == 1)
        chk(tx_ready, 0);
      while (((m == 2) ? u_spn_host.log_q.size() : u_spn_host.main_q.size()) < n)
        @(posedge core_clk);
      foreach (exp_q[k])
      begin
        got = (m == 2) ? u_spn_host.log_q.pop_front() : u_spn_host.main_q.pop_front();
        chk(got, exp_q[k]);
      end
      tick(40);
    end
    // sample gating, sleep, wake and the slow clock
    @(posedge core_clk);
    adc_strobe <= 1'b1;
    seed = lfsr(seed);
    t0 = seed;
    adc_sample <= seed[9:0];
    @(posedge core_clk);
    adc_strobe <= 1'b0;
    deep_sleep_state <= 1'b1;
    tick(2);
    chk(adc_value, t0[9:0]);
    chk(radio_enable, 0);
    chk(wake_request, 0);
    @(posedge core_clk);
    adc_strobe <= 1'b1;
    adc_sample <= ~t0[9:0];
    tau_expired <= 1'b1;
    @(posedge core_clk);
    adc_strobe <= 1'b0;
    tick(1);
    chk(adc_value, t0[9:0]);
    chk(wake_request, 1);
    @(posedge core_clk);
    tau_expired <= 1'b0;
    // take the start count between edges so exactly 40 edges follow
    tick(0);
    t0 = rtc_count;
    tick(40);
    chk(rtc_count - t0, 10);
    // main receive while asleep, last frame with a low stop bit
    exp_q = {};
    @(posedge core_clk);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      exp_q.push_back((k == 3) ? 9'h000 : {1'b1, seed[7:0]});
      u_spn_host.send(seed[7:0], k != 3);
    end
    tick(40);
    chk(rx_q.size(), 4);
    foreach (exp_q[k])
      chk(rx_q[k], exp_q[k]);
    // main transmit while asleep: pending byte raises wake and still goes out
    exp_q = {};
    push(1'b0);
    tx_valid <= 1'b0;
    tick(1);
    chk(wake_request, 1);
    while (u_spn_host.main_q.size() < 1)
      @(posedge core_clk);
    got = u_spn_host.main_q.pop_front();
    chk(got, exp_q[0]);
    complete_run();
  end
endmodule
